// ---- pss_pkg.sv ----
// Constants for the strap, skew and idle-threshold register bank
package pss_pkg;

   // ****************************************
   // Register indexes and byte addresses
   // ****************************************
   localparam logic [7:0] IDX_IDLE_CFG = 8'h53;
   localparam logic [7:0] IDX_SKEW_STS = 8'h55;
   localparam logic [7:0] IDX_STRAP_ONE = 8'h6E;
   localparam logic [7:0] IDX_STRAP_TWO = 8'h6F;
   localparam logic [31:0] ADDR_IDLE_CFG = 32'({IDX_IDLE_CFG, 2'b00});
   localparam logic [31:0] ADDR_SKEW_STS = 32'({IDX_SKEW_STS, 2'b00});
   localparam logic [31:0] ADDR_STRAP_ONE = 32'({IDX_STRAP_ONE, 2'b00});
   localparam logic [31:0] ADDR_STRAP_TWO = 32'({IDX_STRAP_TWO, 2'b00});

   // ****************************************
   // Field layout and reset values
   // ****************************************
   localparam int THR_W = 4;
   localparam int SKEW_W = 4;
   localparam logic [11:0] IDLE_CFG_RSVD = 12'h205;
   localparam logic [3:0] IDLE_THR_RESET = 4'h5;
   localparam logic [3:0] IDLE_CNT_MAX = 4'hF;
   localparam logic [15:0] STRAP_RESET = 16'h0000;

   localparam int B_MIRROR = 15;
   localparam int B_DOWNSHIFT = 14;
   localparam int B_CLKOUT_OFF = 13;
   localparam int B_GMAC_OFF = 12;
   localparam int B_STS1_RSVD = 11;
   localparam int B_XOVER_OFF = 10;
   localparam int B_FORCE_X = 9;
   localparam int B_HALF_DUP = 8;
   localparam int B_ANEG_OFF = 7;
   localparam int B_SPEED_HI = 6;
   localparam int B_SPEED_LO = 5;
   localparam int B_ADDR_HI = 4;
   localparam int B_ADDR_LO = 0;
   localparam int B_FAST_DROP = 10;
   localparam int B_TX_DLY_LO = 4;
   localparam int B_RX_DLY_LO = 0;
   localparam int B_STS2_RSVD = 3;

   // ****************************************
   // Bus encodings
   // ****************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic HRESP_OKAY = 1'b0;

endpackage : pss_pkg

// ---- pss_regs.sv ----
// Strap status, receive skew status and idle-threshold register bank
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
// Overview of operation
// - Idle mode once consecutive idles reach threshold
// - Skew register bits 7:4 show channel B
// - Bits 3:0 show channel A; upper byte zero
// - Bit 15 shows mirroring strap
// - Bit 14 shows downshift strap
// - Bit 13 clock output off, large package only
// - Bit 12 gigabit interface off; bit 11 zero
// - Bit 10 shows crossover detection off
// - Bit 9 shows forced crossed configuration
// - Bit 8 shows half duplex strap
// - Bit 7 shows autonegotiation off
// - Speed select two bits large, one small
// - Address five bits large, four small
// - Second register bit 10 fast drop; 15:11 zero
// - Small package bits 6:4 transmit delay
// - Small package bits 2:0 receive delay; 3 zero
module pss_regs #(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic rx_symbol_valid,
   input wire logic rx_symbol_idle,
   output logic idle_mode,
   input wire logic [pss_pkg::SKEW_W-1:0] rx_chan_a_skew_cycles,
   input wire logic [pss_pkg::SKEW_W-1:0] rx_chan_b_skew_cycles,
   input wire logic strap_mirror_en,
   input wire logic strap_downshift_en,
   input wire logic strap_clock_output_off,
   input wire logic strap_reduced_gmac_if_off,
   input wire logic strap_auto_crossover_off,
   input wire logic strap_forced_crossover,
   input wire logic strap_half_duplex,
   input wire logic strap_autoneg_off,
   input wire logic [1:0] strap_speed_select_wide,
   input wire logic [4:0] strap_mgmt_address,
   input wire logic strap_fast_drop,
   input wire logic [2:0] strap_tx_clk_delay,
   input wire logic [2:0] strap_rx_clk_delay
);
   import pss_pkg::*;

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ****************************************
   // Bus address phase
   // ****************************************
   logic addr_take;
   logic wr_pend;
   logic [31:0] wr_addr;
   logic [THR_W-1:0] idle_thr;
   logic [15:0] strap_one;
   logic [15:0] strap_two;
   logic strap_taken;
   logic [15:0] next_rdata;

   assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_addr <= 32'h0000_0000;
      end else begin
         wr_pend <= addr_take && hwrite;
         wr_addr <= haddr;
      end
   end

   // ****************************************
   // Idle threshold register
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_thr <= IDLE_THR_RESET;
      end else if (wr_pend && (wr_addr == ADDR_IDLE_CFG)) begin
         idle_thr <= hwdata[THR_W-1:0];
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always_comb begin
      next_rdata = 16'h0000;
      case (haddr)
         ADDR_IDLE_CFG: begin
            if (wr_pend && (wr_addr == ADDR_IDLE_CFG)) begin
               next_rdata = {IDLE_CFG_RSVD, hwdata[THR_W-1:0]};
            end else begin
               next_rdata = {IDLE_CFG_RSVD, idle_thr};
            end
         end
         ADDR_SKEW_STS: begin
            next_rdata = {8'h00, rx_chan_b_skew_cycles, rx_chan_a_skew_cycles};
         end
         ADDR_STRAP_ONE: begin
            next_rdata = strap_one;
         end
         ADDR_STRAP_TWO: begin
            next_rdata = strap_two;
         end
         default: begin
            next_rdata = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_take && !hwrite) begin
         hrdata <= {16'h0000, next_rdata};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end

   // ****************************************
   // Strap capture
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_taken <= 1'b0;
         strap_one <= STRAP_RESET;
         strap_two <= STRAP_RESET;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         strap_one <= STRAP_RESET;
         strap_two <= STRAP_RESET;
         strap_one[B_MIRROR] <= strap_mirror_en;
         strap_one[B_DOWNSHIFT] <= strap_downshift_en;
         strap_one[B_CLKOUT_OFF] <= LARGE_PACKAGE && strap_clock_output_off;
         strap_one[B_GMAC_OFF] <= strap_reduced_gmac_if_off;
         strap_one[B_XOVER_OFF] <= strap_auto_crossover_off;
         strap_one[B_FORCE_X] <= strap_forced_crossover;
         strap_one[B_HALF_DUP] <= strap_half_duplex;
         strap_one[B_ANEG_OFF] <= strap_autoneg_off;
         strap_two[B_FAST_DROP] <= strap_fast_drop;
         if (LARGE_PACKAGE) begin
            strap_one[B_SPEED_HI:B_SPEED_LO] <= strap_speed_select_wide;
            strap_one[B_ADDR_HI:B_ADDR_LO] <= strap_mgmt_address;
         end else begin
            strap_one[B_SPEED_LO] <= strap_speed_select_wide[0];
            strap_one[B_ADDR_HI-1:B_ADDR_LO] <= strap_mgmt_address[3:0];
            strap_two[B_TX_DLY_LO+:3] <= strap_tx_clk_delay;
            strap_two[B_RX_DLY_LO+:3] <= strap_rx_clk_delay;
         end
      end
   end

   // ****************************************
   // Idle symbol detector
   // ****************************************
   logic [THR_W-1:0] idle_count;
   logic [THR_W-1:0] next_count;

   always_comb begin
      next_count = idle_count;
      if (idle_count != IDLE_CNT_MAX) begin
         next_count = idle_count + 4'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_count <= 4'h0;
         idle_mode <= 1'b0;
      end else if (rx_symbol_valid) begin
         if (rx_symbol_idle) begin
            idle_count <= next_count;
            idle_mode <= (next_count >= idle_thr);
         end else begin
            idle_count <= 4'h0;
            idle_mode <= 1'b0;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_idle_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_symbol_valid && !rx_symbol_idle |=> !idle_mode)
      else $error("idle mode held after a non-idle symbol");

   chk_idle_enter: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_symbol_valid && rx_symbol_idle && (next_count >= idle_thr) |=> idle_mode)
      else $error("idle mode not entered at threshold");

   chk_thr_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      addr_take && hwrite && (haddr == ADDR_IDLE_CFG)
      ##1 1'b1 |=> idle_thr == $past(hwdata[THR_W-1:0]))
      else $error("threshold write not stored");

   chk_skew_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      addr_take && !hwrite && (haddr == ADDR_SKEW_STS) |=>
      hrdata[15:0] == {8'h00, $past(rx_chan_b_skew_cycles), $past(rx_chan_a_skew_cycles)})
      else $error("skew status read mismatch");

   chk_strap_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      strap_taken |=> $stable(strap_one) && $stable(strap_two))
      else $error("strap value changed after capture");

   chk_sts1_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      addr_take && !hwrite && (haddr == ADDR_STRAP_ONE) && strap_taken |=>
      !hrdata[B_STS1_RSVD] && (hrdata[B_MIRROR] == strap_one[B_MIRROR]))
      else $error("strap status one read mismatch");

   chk_sts2_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      addr_take && !hwrite && (haddr == ADDR_STRAP_TWO) |=>
      (hrdata[15:11] == 5'h00) && !hrdata[B_STS2_RSVD])
      else $error("strap status two reserved bits set");

   chk_pkg_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
      strap_taken |->
      (LARGE_PACKAGE ? ((strap_two[B_TX_DLY_LO+:3] == 3'h0) && (strap_two[B_RX_DLY_LO+:3] == 3'h0)) :
      (!strap_one[B_SPEED_HI] && !strap_one[B_ADDR_HI] && !strap_one[B_CLKOUT_OFF])))
      else $error("package field not masked");

   chk_ro_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_pend && (wr_addr == ADDR_STRAP_ONE) && strap_taken |=> $stable(strap_one))
      else $error("write altered strap status");

   chk_mirror_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      strap_one[B_MIRROR] == $past(strap_mirror_en))
      else $error("mirror strap not captured");

   chk_downshift_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      strap_one[B_DOWNSHIFT] == $past(strap_downshift_en))
      else $error("downshift strap not captured");

   chk_clkout_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      strap_one[B_CLKOUT_OFF] == (LARGE_PACKAGE && $past(strap_clock_output_off)))
      else $error("clock output strap not captured");

   chk_gmac_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      (strap_one[B_GMAC_OFF] == $past(strap_reduced_gmac_if_off)) && !strap_one[B_STS1_RSVD])
      else $error("interface strap not captured");

   chk_xover_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      strap_one[B_XOVER_OFF] == $past(strap_auto_crossover_off))
      else $error("crossover detection strap not captured");

   chk_forced_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      strap_one[B_FORCE_X] == $past(strap_forced_crossover))
      else $error("forced crossover strap not captured");

   chk_duplex_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      strap_one[B_HALF_DUP] == $past(strap_half_duplex))
      else $error("duplex strap not captured");

   chk_aneg_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      strap_one[B_ANEG_OFF] == $past(strap_autoneg_off))
      else $error("autonegotiation strap not captured");

   chk_speed_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |-> strap_one[B_SPEED_HI:B_SPEED_LO] ==
      (LARGE_PACKAGE ? $past(strap_speed_select_wide) : {1'b0, $past(strap_speed_select_wide[0])}))
      else $error("speed select strap not captured");

   chk_addr_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |-> strap_one[B_ADDR_HI:B_ADDR_LO] ==
      (LARGE_PACKAGE ? $past(strap_mgmt_address) : {1'b0, $past(strap_mgmt_address[3:0])}))
      else $error("address strap not captured");

   chk_fast_drop_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      (strap_two[B_FAST_DROP] == $past(strap_fast_drop)) && (strap_two[15:11] == 5'h00))
      else $error("fast drop strap not captured");

   chk_tx_delay_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |->
      strap_two[B_TX_DLY_LO+:3] == (LARGE_PACKAGE ? 3'h0 : $past(strap_tx_clk_delay)))
      else $error("transmit delay strap not captured");

   chk_rx_delay_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(strap_taken) |-> !strap_two[B_STS2_RSVD] &&
      (strap_two[B_RX_DLY_LO+:3] == (LARGE_PACKAGE ? 3'h0 : $past(strap_rx_clk_delay))))
      else $error("receive delay strap not captured");

   chk_idle_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !rx_symbol_valid |=>
      $stable(idle_mode))
      else $error("idle mode changed without a symbol");

   chk_count_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_symbol_valid && !rx_symbol_idle |=>
      idle_count == 4'h0)
      else $error("idle count not cleared by a non-idle symbol");

   chk_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_symbol_valid && rx_symbol_idle && (idle_count != IDLE_CNT_MAX) |=>
      idle_count == $past(idle_count) + 4'h1)
      else $error("idle count did not advance");

   chk_thr_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(rst_n) |->
      idle_thr == IDLE_THR_RESET)
      else $error("threshold not at reset value");

   chk_rsvd_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      addr_take && !hwrite && (haddr == ADDR_IDLE_CFG) |=>
      hrdata[15:THR_W] == IDLE_CFG_RSVD)
      else $error("threshold register upper field mismatch");

endmodule : pss_regs

// ---- pss_regs_tb.sv ----
// Self-checking testbench for the strap, skew and idle-threshold register bank
`timescale 1ns/100ps
module tb;
   import pss_pkg::*;
   logic ref_clk, arst_n, hsel, hwrite, hreadyout, hresp, idle_mode;
   logic rx_symbol_valid, rx_symbol_idle;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [3:0] skew_a, skew_b;
   logic [21:0] straps;
   int n_errors = 0;
   int checks_done = 0;

   pss_regs pss_regs_inst (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .rx_symbol_valid(rx_symbol_valid), .rx_symbol_idle(rx_symbol_idle),
      .idle_mode(idle_mode), .rx_chan_a_skew_cycles(skew_a), .rx_chan_b_skew_cycles(skew_b),
      .strap_mirror_en(straps[21]), .strap_downshift_en(straps[20]),
      .strap_clock_output_off(straps[19]), .strap_reduced_gmac_if_off(straps[18]),
      .strap_auto_crossover_off(straps[17]), .strap_forced_crossover(straps[16]),
      .strap_half_duplex(straps[15]), .strap_autoneg_off(straps[14]),
      .strap_speed_select_wide(straps[13:12]), .strap_mgmt_address(straps[11:7]),
      .strap_fast_drop(straps[6]), .strap_tx_clk_delay(straps[5:3]),
      .strap_rx_clk_delay(straps[2:0]));

   // ****************************************
   // Clock, checks and bus cycles
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         $display("Error at %0t: %s read %h, expected %h", $time, what, got, exp);
         n_errors++;
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'b010;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
      chk({31'h0000_0000, hresp}, {31'h0000_0000, HRESP_OKAY}, "response");
   endtask : bus

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp, "register");
   endtask : rd_chk

   task automatic do_reset();
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      chk({30'h0000_0000, hreadyout, idle_mode}, 32'h0000_0002, "reset outputs");
      arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask : do_reset

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_straps();
      rd_chk(ADDR_STRAP_ONE, 32'h0000_A555);
      rd_chk(ADDR_STRAP_TWO, 32'h0000_0400);
      straps <= 22'h15_5515;
      bus(1'b1, ADDR_STRAP_ONE, 32'hFFFF_FFFF);
      bus(1'b1, ADDR_STRAP_TWO, 32'hFFFF_FFFF);
      rd_chk(ADDR_STRAP_ONE, 32'h0000_A555);
      rd_chk(ADDR_STRAP_TWO, 32'h0000_0400);
      do_reset();
      rd_chk(ADDR_IDLE_CFG, 32'h0000_2055);
      rd_chk(ADDR_STRAP_ONE, 32'h0000_52AA);
      rd_chk(ADDR_STRAP_TWO, 32'h0000_0000);
   endtask : t_straps

   task automatic t_skew();
      skew_a <= 4'h3;
      skew_b <= 4'hC;
      bus(1'b1, ADDR_SKEW_STS, 32'hFFFF_FFFF);
      rd_chk(ADDR_SKEW_STS, 32'h0000_00C3);
      rd_chk(32'h0000_0150, 32'h0000_0000);
   endtask : t_skew

   task automatic t_idle();
      logic [5:0] sym;
      logic [5:0] exp;
      sym = 6'b00_1111;
      exp = 6'b01_0000;
      rd_chk(ADDR_IDLE_CFG, 32'h0000_2055);
      bus(1'b1, ADDR_IDLE_CFG, 32'hFFFF_FFF4);
      rd_chk(ADDR_IDLE_CFG, 32'h0000_2054);
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         rx_symbol_valid <= (i < 5);
         rx_symbol_idle <= sym[i];
         #1;
         chk({31'h0000_0000, idle_mode}, {31'h0000_0000, exp[i]}, "idle mode");
      end
   endtask : t_idle

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      rx_symbol_valid = 1'b0;
      rx_symbol_idle = 1'b0;
      skew_a = 4'h0;
      skew_b = 4'h0;
      straps = 22'h2A_AAEA;
      do_reset();
      t_idle();
      t_skew();
      t_straps();
      give_verdict();
   end

   initial begin
      #(40 * 3000);
      n_errors++;
      give_verdict();
   end
endmodule : tb
